// >>> hw/stepper_mode_ctrl.sv
// Drive-mode control of a two-channel stepper driver: mode word, ramp word,
// step generation, position marker and channel phase outputs.
// Assumes a host that writes words on the register port synchronously.
//
// Contract
// - Stop mode steps until marker low, holds
// - Stop mode keeps programmed pulse count
// - Stop at marker low gives no pulses
// - Output enable clear makes outputs high impedance
// - Output enable clear is not standby
// - Excitation position kept while outputs disabled; the wait-end snap still moves it
// - Mode bit selects microstep or two-phase
// - Zero count, full duty: snap after wait
// - Zero count, constant current: keep position
// - First two-phase pulse jumps next quadrant
// - One-phase rest belongs to forward quadrant
// - Two-phase current: full duty or equal
// - Marker count: once or four per cycle
// - Marker position: one-phase or two-phase
// - No marker at reset position when two-phase
// - Ramp word changes pulse cycle gradually
// - Default ramp word: no ramp, x1
// - Multiplier codes give x1, x2, x4
// - Multiplier extends count, 64 steps/cycle
// - Ramp word bit enables acceleration
// - Ramp word bit enables deceleration
// - Channel 2 lags forward, leads reverse
`timescale 1ns/10ps
module stepper_mode_ctrl #(
	parameter int START_WAIT_CYC_P = stepper_mode_pkg::START_WAIT_CYC
) (
	// Clock and reset
	input  wire logic                                  I_REF_CLK,
	input  wire logic                                  I_SYS_RST,
	// Register port
	input  wire logic [stepper_mode_pkg::ADDR_W-1:0]   I_ADDR,
	input  wire logic [stepper_mode_pkg::DATA_W-1:0]   I_WDATA,
	input  wire logic                                  I_WR,
	input  wire logic                                  I_RD,
	output logic      [stepper_mode_pkg::DATA_W-1:0]   O_RDATA,
	// Motor side
	output logic      [stepper_mode_pkg::POS_W-1:0]    O_CH1_POS,
	output logic      [stepper_mode_pkg::POS_W-1:0]    O_CH2_POS,
	output logic                                       O_DRIVE_EN,
	output logic                                       O_FULL_DUTY,
	output logic                                       O_EQUAL_CURRENT,
	output logic                                       O_STEP_PULSE,
	output logic                                       O_POSITION_MARKER_N,
	output logic                                       O_BUSY
);
	import stepper_mode_pkg::*;

	// ****************************************
	// Registers
	// ****************************************
	logic [DATA_W-1:0] drive_mode;
	logic [DATA_W-1:0] ramp_mult;
	logic [DATA_W-1:0] pulse_count;
	logic [REM_W-1:0]  remaining;
	logic [POS_W-1:0]  pos;
	logic [IVL_W-1:0]  tick_cnt;
	logic [LVL_W-1:0]  ramp_level;
	logic [WAIT_W-1:0] wait_cnt;
	mode_state_t       state;
	logic              wr_drive;
	logic              wr_count;
	logic              two_phase;
	logic              fwd;
	logic              stop_on;
	logic              stepping;
	logic              step_tick;
	logic              marker_now;
	logic              tp_switch;
	logic [1:0]        mult_shift;
	logic [REM_W-1:0]  next_remaining;
	logic [IVL_W-1:0]  interval;
	logic [POS_W-1:0]  next_pos;
	logic [POS_W-1:0]  ch_pos [2];

	assign wr_drive  = I_WR && (I_ADDR == ADDR_DRIVE_MODE);
	assign wr_count  = I_WR && (I_ADDR == ADDR_PULSE_COUNT);
	assign two_phase = drive_mode[DM_TWO_PHASE_BIT];
	assign fwd       = !drive_mode[DM_DIR_BIT];
	assign stop_on   = drive_mode[DM_STOP_BIT];

	// ****************************************
	// Register writes
	// ****************************************
	// Writes are taken whatever the state; the host keeps quiet while a stop seek runs.
	always_ff @(posedge I_REF_CLK) begin
		if (I_SYS_RST) begin
			drive_mode <= DRIVE_MODE_RST;
			ramp_mult  <= RAMP_MULT_RST;
		end else if (wr_drive) begin
			drive_mode <= I_WDATA;
		end else if (I_WR && (I_ADDR == ADDR_RAMP_MULT)) begin
			ramp_mult <= I_WDATA;
		end
	end

	always_ff @(posedge I_REF_CLK) begin
		if (I_SYS_RST) begin
			pulse_count <= PULSE_COUNT_RST;
		end else if (wr_count) begin
			pulse_count <= I_WDATA;
		end
	end

	// ****************************************
	// Pulse count multiplier
	// ****************************************
	always_comb begin
		case (ramp_mult[1:0])
			MULT_X2: mult_shift = 2'd1;
			MULT_X4: mult_shift = 2'd2;
			default: mult_shift = 2'd0;
		endcase
		// In microstep mode position still advances one microstep per pulse, only the count grows
		next_remaining = REM_W'({2'b00, I_WDATA}) << mult_shift;
	end

	// ****************************************
	// Step rate divider with ramp
	// ****************************************
	assign interval  = STEP_BASE_CYC + IVL_W'(ramp_level) * RAMP_UNIT_CYC;
	// Stepping pauses while outputs are off so the excitation position survives
	assign stepping  = ((state == ST_MOVE) || (state == ST_SEEK)) && drive_mode[DM_OE_BIT];
	assign step_tick = stepping && (tick_cnt == '0);

	always_ff @(posedge I_REF_CLK) begin
		if (I_SYS_RST) begin
			tick_cnt <= '0;
		end else if (!stepping || (tick_cnt == '0)) begin
			tick_cnt <= interval;
		end else begin
			tick_cnt <= tick_cnt - 1'b1;
		end
	end

	always_ff @(posedge I_REF_CLK) begin
		if (I_SYS_RST) begin
			ramp_level <= '0;
		end else if (wr_count && (state == ST_IDLE || state == ST_WAIT)) begin
			ramp_level <= ramp_mult[RM_ACCEL_BIT] ? RAMP_LEVELS : '0;
		end else if (state == ST_SEEK) begin
			ramp_level <= '0;
		end else if (step_tick) begin
			if (ramp_mult[RM_DECEL_BIT] && (remaining <= REM_W'(RAMP_LEVELS))) begin
				if (ramp_level < RAMP_LEVELS) begin
					ramp_level <= ramp_level + 1'b1;
				end
			end else if (ramp_level != '0) begin
				ramp_level <= ramp_level - 1'b1;
			end
		end
	end

	// ****************************************
	// Position marker
	// ****************************************
	always_comb begin
		if (two_phase) begin
			marker_now = (pos == {2'b00, TWO_PH_OFS});
		end else if (drive_mode[DM_MARK_POS_BIT]) begin
			// Two-phase points only, so position zero never marks
			marker_now = (pos[3:0] == TWO_PH_OFS) &&
				(drive_mode[DM_MARK_COUNT_BIT] || pos[5:4] == 2'b00);
		end else begin
			marker_now = (pos[3:0] == ONE_PH_OFS) &&
				(drive_mode[DM_MARK_COUNT_BIT] || pos[5:4] == 2'b00);
		end
	end

	// ****************************************
	// Sequencer
	// ****************************************
	assign tp_switch = wr_drive && I_WDATA[DM_TWO_PHASE_BIT] && !two_phase;

	always_ff @(posedge I_REF_CLK) begin
		if (I_SYS_RST) begin
			state     <= ST_IDLE;
			remaining <= '0;
			wait_cnt  <= '0;
		end else begin
			case (state)
				ST_IDLE, ST_WAIT: begin
					if (stop_on) begin
						state <= marker_now ? ST_HELD : ST_SEEK;
					end else if (wr_count && (I_WDATA != '0)) begin
						remaining <= next_remaining;
						state     <= ST_MOVE;
					end else if (tp_switch && (state == ST_IDLE)) begin
						wait_cnt <= WAIT_W'(START_WAIT_CYC_P);
						state    <= ST_WAIT;
					end else if (state == ST_WAIT) begin
						if (wait_cnt == '0) begin
							state <= ST_IDLE;
						end else begin
							wait_cnt <= wait_cnt - 1'b1;
						end
					end
				end
				ST_MOVE: begin
					if (stop_on) begin
						state <= marker_now ? ST_HELD : ST_SEEK;
					end else if (step_tick) begin
						remaining <= remaining - 1'b1;
						if (remaining == REM_W'(1)) begin
							state <= ST_IDLE;
						end
					end
				end
				ST_SEEK: begin
					// Remaining count is left as it is while seeking
					if (marker_now) begin
						state <= ST_HELD;
					end
				end
				default: begin
					if (!stop_on) begin
						state <= (remaining != '0) ? ST_MOVE : ST_IDLE;
					end
				end
			endcase
		end
	end

	// ****************************************
	// Excitation position
	// ****************************************
	always_comb begin
		next_pos = pos;
		if (step_tick) begin
			if (!two_phase) begin
				next_pos = fwd ? pos + 1'b1 : pos - 1'b1;
			end else if (pos[3:0] != TWO_PH_OFS) begin
				// Quadrant taken from the upper bits, so a one-phase rest counts forward
				next_pos = fwd ? {pos[5:4] + 2'b01, TWO_PH_OFS}
					: {pos[5:4] - 2'b01, TWO_PH_OFS};
			end else begin
				next_pos = fwd ? pos + QUAD_STEP : pos - QUAD_STEP;
			end
		end else if ((state == ST_WAIT) && (wait_cnt == '0) && !stop_on
			&& !drive_mode[DM_TP_CURRENT_BIT]) begin
			next_pos = {pos[5:4], TWO_PH_OFS};
		end
	end

	// Output enable gates drivers and stepping; position keeps its value bar the wait-end snap
	always_ff @(posedge I_REF_CLK) begin
		if (I_SYS_RST) begin
			pos <= '0;
		end else begin
			pos <= next_pos;
		end
	end

	// ****************************************
	// Channel phases
	// ****************************************
	for (genvar ch = 0; ch < 2; ch++) begin : g_chan
		always_ff @(posedge I_REF_CLK) begin
			if (I_SYS_RST) begin
				ch_pos[ch] <= '0;
			end else if (ch == 0) begin
				ch_pos[ch] <= pos;
			end else begin
				ch_pos[ch] <= fwd ? pos - QUAD_STEP : pos + QUAD_STEP;
			end
		end
	end
	assign O_CH1_POS = ch_pos[0];
	assign O_CH2_POS = ch_pos[1];

	// ****************************************
	// Outputs
	// ****************************************
	always_ff @(posedge I_REF_CLK) begin
		if (I_SYS_RST) begin
			O_DRIVE_EN          <= 1'b0;
			O_FULL_DUTY         <= 1'b0;
			O_EQUAL_CURRENT     <= 1'b0;
			O_STEP_PULSE        <= 1'b0;
			O_POSITION_MARKER_N <= 1'b1;
			O_BUSY              <= 1'b0;
		end else begin
			O_DRIVE_EN          <= drive_mode[DM_OE_BIT];
			O_FULL_DUTY         <= two_phase && !drive_mode[DM_TP_CURRENT_BIT]
				&& (state != ST_WAIT);
			O_EQUAL_CURRENT     <= two_phase && drive_mode[DM_TP_CURRENT_BIT];
			O_STEP_PULSE        <= step_tick;
			O_POSITION_MARKER_N <= !marker_now;
			O_BUSY              <= (state != ST_IDLE);
		end
	end

	// ****************************************
	// Register reads
	// ****************************************
	always_ff @(posedge I_REF_CLK) begin
		if (I_SYS_RST || !I_RD) begin
			O_RDATA <= '0;
		end else if (I_ADDR == ADDR_DRIVE_MODE) begin
			O_RDATA <= drive_mode;
		end else if (I_ADDR == ADDR_PULSE_COUNT) begin
			O_RDATA <= pulse_count;
		end else if (I_ADDR == ADDR_STATUS) begin
			O_RDATA <= '0;
			O_RDATA[ST_POS_LSB +: POS_W] <= pos;
			O_RDATA[ST_MARK_BIT]         <= marker_now;
			O_RDATA[ST_MOVE_BIT]         <= (state == ST_MOVE);
			O_RDATA[ST_SEEK_BIT]         <= (state == ST_SEEK);
			O_RDATA[ST_HELD_BIT]         <= (state == ST_HELD);
			O_RDATA[ST_WAIT_BIT]         <= (state == ST_WAIT);
		end else begin
			O_RDATA <= '0;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	sequence s_mark_reached;
		(state == ST_SEEK) && marker_now && stop_on;
	endsequence

	sequence s_held_quiet;
		(state == ST_HELD) && !step_tick ##1 !O_STEP_PULSE;
	endsequence

	AST_SEEK_THEN_HOLD: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
		s_mark_reached |=> s_held_quiet)
		else $error("Stop seek did not hold at the marker");

	AST_HELD_NO_STEP: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
		(state == ST_IDLE) && stop_on && marker_now |=> (state == ST_HELD) ##1 !O_STEP_PULSE)
		else $error("Step issued after stop at marker");

	AST_SEEK_KEEPS_COUNT: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
		(state == ST_SEEK) && !wr_count |=> $stable(pulse_count) && $stable(remaining))
		else $error("Count changed during stop seek");

	AST_OE_TO_PIN: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
		wr_drive |-> ##2 (O_DRIVE_EN == $past(I_WDATA[DM_OE_BIT], 2)))
		else $error("Drive enable does not follow the mode word");

	AST_OFF_POS_KEPT: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
		!drive_mode[DM_OE_BIT] && (state != ST_WAIT) |=> pos == $past(pos))
		else $error("Position moved with outputs disabled");

	AST_MULT_LOAD: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
		(state == ST_IDLE) && !stop_on && wr_count && (I_WDATA != '0) && ramp_mult[1:0] == MULT_X4
		|=> remaining == {$past(I_WDATA), 2'b00})
		else $error("Multiplied count wrong");

	AST_TP_JUMP: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
		step_tick && two_phase |=> pos[3:0] == TWO_PH_OFS)
		else $error("Two-phase step left a two-phase point");

	AST_NO_MARK_AT_ZERO: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
		!two_phase && drive_mode[DM_MARK_POS_BIT] && (pos == '0) |=> O_POSITION_MARKER_N)
		else $error("Marker at reset position");

	AST_CH2_LAG: assert property (@(posedge I_REF_CLK) disable iff (I_SYS_RST)
		fwd && $stable(fwd) |=> O_CH2_POS == $past(pos) - QUAD_STEP)
		else $error("Channel 2 not a quarter cycle behind");

endmodule

// >>> hw/stepper_mode_pkg.sv
// Constants and types shared by the stepper drive-mode control block.
// Assumes a single 25 MHz reference clock and a plain register port.
package stepper_mode_pkg;

	// ****************************************
	// Register port and offsets
	// ****************************************
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	localparam logic [ADDR_W-1:0] ADDR_DRIVE_MODE  = 4'h2;
	localparam logic [ADDR_W-1:0] ADDR_RAMP_MULT   = 4'h3;
	localparam logic [ADDR_W-1:0] ADDR_PULSE_COUNT = 4'h5;
	localparam logic [ADDR_W-1:0] ADDR_STATUS      = 4'h8;

	// ****************************************
	// Field positions and reset values
	// ****************************************
	localparam int DM_DIR_BIT        = 5;
	localparam int DM_STOP_BIT       = 6;
	localparam int DM_OE_BIT         = 7;
	localparam int DM_TWO_PHASE_BIT  = 8;
	localparam int DM_TP_CURRENT_BIT = 9;
	localparam int DM_MARK_COUNT_BIT = 10;
	localparam int DM_MARK_POS_BIT   = 11;
	localparam int RM_DECEL_BIT      = 9;
	localparam int RM_ACCEL_BIT      = 10;
	localparam logic [1:0] MULT_X2   = 2'h2;
	localparam logic [1:0] MULT_X4   = 2'h3;
	localparam logic [DATA_W-1:0] DRIVE_MODE_RST  = 16'h0000;
	localparam logic [DATA_W-1:0] RAMP_MULT_RST   = 16'h0000;
	localparam logic [DATA_W-1:0] PULSE_COUNT_RST = 16'h0000;
	localparam int ST_POS_LSB     = 0;
	localparam int ST_MARK_BIT    = 6;
	localparam int ST_MOVE_BIT    = 7;
	localparam int ST_SEEK_BIT    = 8;
	localparam int ST_HELD_BIT    = 9;
	localparam int ST_WAIT_BIT    = 10;

	// ****************************************
	// Excitation position
	// ****************************************
	localparam int POS_W = 6;
	localparam int REM_W = 18;
	localparam logic [POS_W-1:0] QUAD_STEP   = 6'h10;
	localparam logic [3:0]       TWO_PH_OFS  = 4'h8;
	localparam logic [3:0]       ONE_PH_OFS  = 4'h0;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_MHZ       = 25;
	localparam int IVL_W         = 12;
	localparam int LVL_W         = 5;
	localparam int WAIT_W        = 15;
	localparam int STEP_BASE_NS  = 80000;
	localparam int RAMP_UNIT_NS  = 4000;
	localparam int START_WAIT_US = 1000;
	localparam logic [IVL_W-1:0] STEP_BASE_CYC = IVL_W'(STEP_BASE_NS * CLK_MHZ / 1000);
	localparam logic [IVL_W-1:0] RAMP_UNIT_CYC = IVL_W'(RAMP_UNIT_NS * CLK_MHZ / 1000);
	localparam logic [LVL_W-1:0] RAMP_LEVELS   = 5'h10;
	localparam int START_WAIT_CYC = START_WAIT_US * CLK_MHZ;

	typedef enum {ST_IDLE, ST_WAIT, ST_MOVE, ST_SEEK, ST_HELD} mode_state_t;

endpackage

// >>> testbench/cmd_host.sv
// Host model that issues command words on the plain register port.
// Assumes the device samples both strobes on the rising clock edge.
`timescale 1ns/10ps
module cmd_host
	import stepper_mode_pkg::*;
(
	// Clock and device status
	input  wire logic              i_clk,
	input  wire logic              i_marker_n,
	input  wire logic [DATA_W-1:0] i_rdata,
	// Register port
	output logic      [ADDR_W-1:0] o_addr,
	output logic      [DATA_W-1:0] o_wdata,
	output logic                   o_wr,
	output logic                   o_rd
);
	// ****************************************
	// Bus cycles
	// ****************************************
	logic stop_on;

	initial begin
		o_addr = '0;
		o_wdata = '0;
		o_wr = 1'b0;
		o_rd = 1'b0;
		stop_on = 1'b0;
	end

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		int n;
		n = 0;
		// Hold off any word while the motor still seeks the marker
		while (stop_on && i_marker_n && n < 20000) begin
			@(posedge i_clk);
			n++;
		end
		@(posedge i_clk);
		o_addr  <= a;
		o_wdata <= d;
		o_wr    <= 1'b1;
		@(posedge i_clk);
		o_wr    <= 1'b0;
		// Idle data must not look like the last word
		o_wdata <= ~d;
		if (a == ADDR_DRIVE_MODE) stop_on = d[DM_STOP_BIT];
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
		@(posedge i_clk);
		o_addr <= a;
		o_rd   <= 1'b1;
		@(posedge i_clk);
		o_rd   <= 1'b0;
		@(posedge i_clk);
		d = i_rdata;
	endtask
endmodule

// >>> testbench/stepper_drive_mode_control_tb.sv
// Self-checking bench of the drive-mode control block.
// Assumes the host model drives every register access.
`timescale 1ns/10ps
module stepper_drive_mode_control_tb;
	import stepper_mode_pkg::*;
	// ****************************************
	// Design, host and clock
	// ****************************************
	logic              I_REF_CLK;
	logic              I_SYS_RST;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic [DATA_W-1:0] rdata;
	logic              wr;
	logic              rd;
	logic [POS_W-1:0]  O_CH1_POS;
	logic [POS_W-1:0]  O_CH2_POS;
	logic              O_DRIVE_EN;
	logic              O_FULL_DUTY;
	logic              O_EQUAL_CURRENT;
	logic              O_STEP_PULSE;
	logic              O_POSITION_MARKER_N;
	logic              O_BUSY;
	logic [15:0]       mode;
	logic [5:0]        pos;
	logic [15:0]       v;
	logic [31:0]       rnd;
	int                error_cnt;
	int                check_count;
	int                steps;
	int                s0;
	int                cyc;
	int                last;
	int                gap;

	stepper_mode_ctrl #(.START_WAIT_CYC_P(8)) u_dut (
		.I_REF_CLK(I_REF_CLK), .I_SYS_RST(I_SYS_RST), .I_ADDR(addr), .I_WDATA(wdata),
		.I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .O_CH1_POS(O_CH1_POS),
		.O_CH2_POS(O_CH2_POS), .O_DRIVE_EN(O_DRIVE_EN), .O_FULL_DUTY(O_FULL_DUTY),
		.O_EQUAL_CURRENT(O_EQUAL_CURRENT), .O_STEP_PULSE(O_STEP_PULSE),
		.O_POSITION_MARKER_N(O_POSITION_MARKER_N), .O_BUSY(O_BUSY));

	cmd_host u_host (.i_clk(I_REF_CLK), .i_marker_n(O_POSITION_MARKER_N), .i_rdata(rdata),
		.o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd));

	initial begin
		I_REF_CLK = 1'b0;
		forever #20 I_REF_CLK = ~I_REF_CLK;
	end

	always @(posedge I_REF_CLK) begin
		cyc++;
		if (O_STEP_PULSE === 1'b1) begin
			steps++;
			gap = cyc - last;
			last = cyc;
		end
	end

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	function automatic logic mark(input logic [5:0] p, input logic [15:0] m);
		if (m[DM_TWO_PHASE_BIT]) return p == 6'h08;
		return (p[3:0] == (m[DM_MARK_POS_BIT] ? 4'h8 : 4'h0))
			&& (m[DM_MARK_COUNT_BIT] || p[5:4] == 2'h0);
	endfunction

	function automatic logic [5:0] nxt(input logic [5:0] p, input logic [15:0] m);
		// Two-phase pulses land on the next quadrant's two-phase point
		if (!m[DM_TWO_PHASE_BIT]) return m[DM_DIR_BIT] ? p - 6'h01 : p + 6'h01;
		if (p[3:0] != 4'h8) return m[DM_DIR_BIT] ? {p[5:4] - 2'h1, 4'h8} : {p[5:4] + 2'h1, 4'h8};
		return m[DM_DIR_BIT] ? p - 6'h10 : p + 6'h10;
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic chk_all;
		check(O_CH1_POS, pos);
		check(O_CH2_POS, mode[DM_DIR_BIT] ? 6'(pos + 6'h10) : 6'(pos - 6'h10));
		check(O_POSITION_MARKER_N, !mark(pos, mode));
		check(O_DRIVE_EN, mode[DM_OE_BIT]);
		check(O_FULL_DUTY, mode[DM_TWO_PHASE_BIT] & ~mode[DM_TP_CURRENT_BIT]);
		check(O_EQUAL_CURRENT, mode[DM_TWO_PHASE_BIT] & mode[DM_TP_CURRENT_BIT]);
	endtask

	task automatic mset(input logic [15:0] m);
		mode = m;
		u_host.wr(ADDR_DRIVE_MODE, m);
		repeat (3) @(posedge I_REF_CLK);
	endtask

	task automatic go(input logic [15:0] n);
		s0 = steps;
		u_host.wr(ADDR_PULSE_COUNT, n);
	endtask

	task automatic fin(input int n_exp);
		int k;
		k = 0;
		repeat (3) @(posedge I_REF_CLK);
		while (O_BUSY !== 1'b0 && k < 20000) begin
			@(posedge I_REF_CLK);
			k++;
		end
		repeat (3) @(posedge I_REF_CLK);
		check(steps - s0, n_exp);
		for (int i = 0; i < n_exp; i++) pos = nxt(pos, mode);
		chk_all;
	endtask

	task automatic tally_and_finish;
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	initial begin
		repeat (90000) @(posedge I_REF_CLK);
		error_cnt++;
		tally_and_finish;
	end

	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		I_SYS_RST = 1'b1;
		rnd = 32'hdf99_555c;
		mode = '0;
		pos = '0;
		repeat (4) @(posedge I_REF_CLK);
		I_SYS_RST <= 1'b0;
		repeat (3) @(posedge I_REF_CLK);
		chk_all;
		u_host.rd(ADDR_RAMP_MULT, v);
		check(v, 16'h0000);
		for (int i = 0; i < 8; i++) begin
			rnd = lfsr(rnd);
			if (!(rnd[19:16] inside {4'h2, 4'h3, 4'h5, 4'h8})) begin
				u_host.wr(rnd[19:16], rnd[15:0]);
				u_host.rd(rnd[19:16], v);
				check(v, 16'h0000);
			end
		end
		mset(16'h0800);
		check(O_POSITION_MARKER_N, 1'b1);
		mset(16'h0080);
		for (int c = 0; c < 4; c++) begin
			u_host.wr(ADDR_RAMP_MULT, 16'(c));
			go(16'h0001);
			fin(c == 3 ? 4 : (c == 2 ? 2 : 1));
		end
		check(gap, STEP_BASE_CYC + 1);
		mset(16'h0880);
		chk_all;
		u_host.wr(ADDR_RAMP_MULT, 16'h0000);
		mset(16'h0000);
		go(16'h0002);
		repeat (2500) @(posedge I_REF_CLK);
		check(steps - s0, 0);
		check(O_BUSY, 1'b1);
		chk_all;
		mset(16'h0080);
		fin(2);
		s0 = steps;
		mset(16'h04C0);
		for (int k = 0; k < 20000 && O_POSITION_MARKER_N !== 1'b0; k++) @(posedge I_REF_CLK);
		repeat (2500) @(posedge I_REF_CLK);
		check(steps - s0, 6);
		pos = 6'h10;
		u_host.rd(ADDR_STATUS, v);
		check(v[ST_HELD_BIT], 1'b1);
		mset(16'h0480);
		chk_all;
		mset(16'h0380);
		repeat (20) @(posedge I_REF_CLK);
		chk_all;
		go(16'h0001);
		fin(1);
		pos = 6'h28;
		chk_all;
		mset(16'h0C00);
		go(16'h0001);
		mset(16'h0CC0);
		repeat (2500) @(posedge I_REF_CLK);
		check(steps - s0, 0);
		mset(16'h0C80);
		fin(1);
		u_host.wr(ADDR_RAMP_MULT, 16'h0600);
		go(16'h0002);
		fin(2);
		check(32'(gap > STEP_BASE_CYC + 1), 32'h1);
		mset(16'h0D80);
		repeat (30) @(posedge I_REF_CLK);
		pos = 6'h28;
		chk_all;
		mset(16'h00A0);
		chk_all;
		// Reverse move, acceleration only: the ramp level drops one per pulse
		u_host.wr(ADDR_RAMP_MULT, 16'h0400);
		go(16'h0003);
		fin(3);
		check(gap, STEP_BASE_CYC + 15 * RAMP_UNIT_CYC + 1);
		tally_and_finish;
	end
endmodule
